/* hw/nibble_xfer_exec.sv */
// executor for register transfer, pointer and ram transfer operations
`timescale 1ns/1ps
// What this block does
// - copy b to acc, b kept
// - copy acc to b, acc kept
// - copy y to acc
// - copy acc to y
// - pack: e high nibble from b, low nibble from acc
// - unpack: b from e high nibble, acc from e low nibble
// - d takes acc bits two to zero
// - acc takes d in low three bits, bit three zero
// - acc takes z in low two bits, upper two bits zero
// - copy x to acc
// - acc takes stack pointer in low three bits, bit three zero
// - load x and y from immediates together
// - back to back xy loads: only the first executes
// - load z from the low two bits of its four bit immediate
// - increment y mod 16, skip next when result zero
// - decrement y mod 16, skip next when result fifteen
// - memory load puts ram nibble at pointer into acc
// - exchanges swap acc with ram nibble at pointer
// - memory store writes acc to ram at pointer
// - all memory operations then xor x with immediate
module nibble_xfer_exec #(
  parameter int ACC_W = xfer_pkg::ACC_W,
  parameter int RAM_AW = xfer_pkg::RAM_AW
) (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rstn,
  // one decoded operation per cycle
  input  wire logic               op_valid,
  input  wire xfer_pkg::op_t      op,
  input  wire logic [3:0]         imm_a,
  input  wire logic [3:0]         imm_b,
  // state owned elsewhere in the core
  input  wire logic [2:0]         stack_pointer,
  input  wire logic               carry_in,
  input  wire logic [RAM_AW-1:0]  data_pointer,
  // data ram at the data pointer
  input  wire logic [3:0]         ram_rdata,
  output logic [RAM_AW-1:0]       ram_addr,
  output logic                    ram_we,
  output logic [3:0]              ram_wdata,
  // architectural state, widths fixed by the core
  output logic [3:0]              acc,
  output logic [3:0]              reg_b,
  output logic [3:0]              reg_x,
  output logic [3:0]              reg_y,
  output logic [7:0]              reg_e,
  output logic [2:0]              reg_d,
  output logic [1:0]              reg_z,
  output logic                    carry_flag,
  // sequencing
  output logic                    skip_pending,
  output logic                    op_executed
);

  // y step used by both plain and exchanging forms
  function automatic logic [3:0] y_step(input logic [3:0] y, input logic up);
    y_step = up ? 4'(y + xfer_pkg::ONE4) : 4'(y - xfer_pkg::ONE4);
  endfunction : y_step

  function automatic logic is_mem(input xfer_pkg::op_t o);
    is_mem = (o == xfer_pkg::op_memory_load_xor_x) ||
             (o == xfer_pkg::op_memory_exchange_xor_x) ||
             (o == xfer_pkg::op_memory_exchange_dec_y) ||
             (o == xfer_pkg::op_memory_exchange_inc_y) ||
             (o == xfer_pkg::op_memory_store_xor_x);
  endfunction : is_mem

  logic skip_next;
  logic prev_xy;
  logic live;
  logic xy_blocked;
  logic [3:0] y_inc;
  logic [3:0] y_dec;

  // an op is live unless the previous set skip or it is a repeated xy load
  assign xy_blocked  = prev_xy && (op == xfer_pkg::op_load_xy_immediate);
  assign live        = op_valid && !skip_next && !xy_blocked;
  assign op_executed = live;
  assign skip_pending = skip_next;
  assign y_inc = y_step(reg_y, 1'b1);
  assign y_dec = y_step(reg_y, 1'b0);

  // ram access is combinational so the read is seen in the same cycle
  assign ram_addr  = data_pointer;
  assign ram_wdata = acc;
  assign ram_we = live && is_mem(op) && (op != xfer_pkg::op_memory_load_xor_x);

  // strobe judged from the decoded op, not from live, so a broken gate shows
  exch_we_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    op_valid && !skip_next && (op == xfer_pkg::op_memory_exchange_xor_x ||
    op == xfer_pkg::op_memory_exchange_dec_y || op == xfer_pkg::op_memory_exchange_inc_y)
    |-> ram_we && ram_wdata == acc)
    else $error("exchange did not write");
  load_no_we_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    op_valid && op == xfer_pkg::op_memory_load_xor_x |-> !ram_we)
    else $error("memory load wrote ram");
  idle_no_we_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !op_valid |-> !ram_we)
    else $error("ram written with no op");

  // remembers whether the last fetched op was an xy load, even if skipped
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      prev_xy <= 1'b0;
    end else if (op_valid) begin
      prev_xy <= (op == xfer_pkg::op_load_xy_immediate);
    end
  end

  // a gap with no fetched op keeps the repeat state alive
  xy_gap_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    op_valid && op == xfer_pkg::op_load_xy_immediate ##1 !op_valid ##1
    op_valid && op == xfer_pkg::op_load_xy_immediate |=> $stable(reg_x) && $stable(reg_y))
    else $error("xy load after gap executed");
  xy_first_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    op_valid && !skip_next && !prev_xy && op == xfer_pkg::op_load_xy_immediate
    |=> reg_x == $past(imm_a) && reg_y == $past(imm_b))
    else $error("xy load wrong");

  // skip flag for the next fetched op; a skipped op never raises a new skip
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      skip_next <= 1'b0;
    end else if (op_valid) begin
      skip_next <= 1'b0;
      if (live) begin
        case (op)
          xfer_pkg::op_increment_y_skip,
          xfer_pkg::op_memory_exchange_inc_y: begin
            skip_next <= (y_inc == xfer_pkg::Y_WRAP_INC);
          end
          xfer_pkg::op_decrement_y_skip,
          xfer_pkg::op_memory_exchange_dec_y: begin
            skip_next <= (y_dec == xfer_pkg::Y_WRAP_DEC);
          end
          default: begin
            skip_next <= 1'b0;
          end
        endcase
      end
    end
  end

  // exchanging forms raise the skip from the stepped y too
  inc_xchg_skip_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    live && op == xfer_pkg::op_memory_exchange_inc_y |=> skip_next == (reg_y == 4'h0))
    else $error("exchange increment skip wrong");
  dec_xchg_skip_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    live && op == xfer_pkg::op_memory_exchange_dec_y |=> skip_next == (reg_y == 4'hf))
    else $error("exchange decrement skip wrong");
  skip_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !op_valid && skip_next |=> skip_next)
    else $error("skip lost in a gap");

  // accumulator
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      acc <= xfer_pkg::ACC_RST;
    end else if (live) begin
      case (op)
        xfer_pkg::op_copy_b_to_acc:         acc <= reg_b;
        xfer_pkg::op_copy_y_to_acc:         acc <= reg_y;
        xfer_pkg::op_unpack_e_to_b_acc:     acc <= reg_e[3:0];
        xfer_pkg::op_read_d_to_acc:         acc <= {1'b0, reg_d};
        xfer_pkg::op_read_z_to_acc:         acc <= {2'b00, reg_z};
        xfer_pkg::op_copy_x_to_acc:         acc <= reg_x;
        xfer_pkg::op_read_stack_ptr_to_acc: acc <= {1'b0, stack_pointer};
        xfer_pkg::op_memory_load_xor_x,
        xfer_pkg::op_memory_exchange_xor_x,
        xfer_pkg::op_memory_exchange_dec_y,
        xfer_pkg::op_memory_exchange_inc_y: acc <= ram_rdata;
        default:                            acc <= acc;
      endcase
    end
  end

  // accumulator sources, each checked against the value before the edge
  copy_y_acc_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    live && op == xfer_pkg::op_copy_y_to_acc |=> acc == $past(reg_y))
    else $error("acc did not take y");
  copy_x_acc_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    live && op == xfer_pkg::op_copy_x_to_acc |=> acc == $past(reg_x))
    else $error("acc did not take x");
  unpack_e_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    live && op == xfer_pkg::op_unpack_e_to_b_acc
    |=> {reg_b, acc} == $past(reg_e))
    else $error("unpack wrong");
  read_d_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    live && op == xfer_pkg::op_read_d_to_acc |=> acc == {1'h0, $past(reg_d)})
    else $error("d read wrong");
  read_z_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    live && op == xfer_pkg::op_read_z_to_acc |=> acc == {2'h0, $past(reg_z)})
    else $error("z read wrong");
  xchg_acc_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    live && (op == xfer_pkg::op_memory_exchange_xor_x ||
    op == xfer_pkg::op_memory_exchange_dec_y || op == xfer_pkg::op_memory_exchange_inc_y)
    |=> acc == $past(ram_rdata))
    else $error("exchange did not load acc");
  store_keep_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    live && op == xfer_pkg::op_memory_store_xor_x |=> $stable(acc))
    else $error("store changed acc");

  // register b
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reg_b <= xfer_pkg::B_RST;
    end else if (live && op == xfer_pkg::op_copy_acc_to_b) begin
      reg_b <= acc;
    end else if (live && op == xfer_pkg::op_unpack_e_to_b_acc) begin
      reg_b <= reg_e[7:4];
    end
  end

  // register e, packed from b and acc
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reg_e <= xfer_pkg::E_RST;
    end else if (live && op == xfer_pkg::op_pack_e_from_b_acc) begin
      reg_e <= {reg_b, acc};
    end
  end

  // register d
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reg_d <= xfer_pkg::D_RST;
    end else if (live && op == xfer_pkg::op_load_d_from_acc) begin
      reg_d <= acc[2:0];
    end
  end

  // only the low three accumulator bits reach d
  load_d_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    live && op == xfer_pkg::op_load_d_from_acc |=> {1'h0, reg_d} == ($past(acc) & 4'h7))
    else $error("d load wrong");

  // register z
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reg_z <= xfer_pkg::Z_RST;
    end else if (live && op == xfer_pkg::op_load_z_immediate) begin
      reg_z <= imm_a[1:0];
    end
  end

  // upper immediate bits are ignored by the z load
  load_z_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    live && op == xfer_pkg::op_load_z_immediate |=> {2'h0, reg_z} == ($past(imm_a) & 4'h3))
    else $error("z load wrong");

  // register x: immediate load or xor after a memory access
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reg_x <= xfer_pkg::X_RST;
    end else if (live && op == xfer_pkg::op_load_xy_immediate) begin
      reg_x <= imm_a;
    end else if (live && is_mem(op)) begin
      reg_x <= reg_x ^ imm_a;
    end
  end

  // register y
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reg_y <= xfer_pkg::Y_RST;
    end else if (live) begin
      case (op)
        xfer_pkg::op_copy_acc_to_y:         reg_y <= acc;
        xfer_pkg::op_load_xy_immediate:     reg_y <= imm_b;
        xfer_pkg::op_increment_y_skip,
        xfer_pkg::op_memory_exchange_inc_y: reg_y <= y_inc;
        xfer_pkg::op_decrement_y_skip,
        xfer_pkg::op_memory_exchange_dec_y: reg_y <= y_dec;
        default:                            reg_y <= reg_y;
      endcase
    end
  end

  // y arithmetic wraps in four bits for plain and exchanging forms
  copy_acc_y_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    live && op == xfer_pkg::op_copy_acc_to_y |=> reg_y == $past(acc))
    else $error("y did not take acc");
  inc_y_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    live && (op == xfer_pkg::op_increment_y_skip || op == xfer_pkg::op_memory_exchange_inc_y)
    |=> reg_y == 4'($past(reg_y) + xfer_pkg::ONE4))
    else $error("y increment wrong");
  dec_y_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    live && (op == xfer_pkg::op_decrement_y_skip || op == xfer_pkg::op_memory_exchange_dec_y)
    |=> reg_y == 4'($past(reg_y) - xfer_pkg::ONE4))
    else $error("y decrement wrong");

  // carry is owned by the arithmetic group; these ops only pass it through
  assign carry_flag = carry_in;

  // checks
  copy_b_acc_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    live && op == xfer_pkg::op_copy_b_to_acc |=> acc == $past(reg_b) && reg_b == $past(reg_b))
    else $error("acc did not take b");
  copy_acc_b_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    live && op == xfer_pkg::op_copy_acc_to_b |=> reg_b == $past(acc) && acc == $past(acc))
    else $error("b did not take acc");
  pack_e_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    live && op == xfer_pkg::op_pack_e_from_b_acc |=> reg_e == {$past(reg_b), $past(acc)})
    else $error("pack wrong");
  pack_keep_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    live && op == xfer_pkg::op_pack_e_from_b_acc |=> $stable(reg_b) && $stable(acc))
    else $error("pack changed b or acc");
  read_stack_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    live && op == xfer_pkg::op_read_stack_ptr_to_acc |=> acc == {1'b0, $past(stack_pointer)})
    else $error("stack pointer read wrong");
  xy_repeat_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    op_valid && op == xfer_pkg::op_load_xy_immediate ##1
    op_valid && op == xfer_pkg::op_load_xy_immediate |=> $stable(reg_x) && $stable(reg_y))
    else $error("repeated xy load executed");
  inc_skip_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    live && op == xfer_pkg::op_increment_y_skip |=> skip_next == (reg_y == 4'h0))
    else $error("increment skip wrong");
  dec_skip_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    live && op == xfer_pkg::op_decrement_y_skip |=> skip_next == (reg_y == 4'hf))
    else $error("decrement skip wrong");
  mem_xor_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    live && is_mem(op) |=> reg_x == ($past(reg_x) ^ $past(imm_a)))
    else $error("x xor update wrong");
  store_we_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    op_valid && !skip_next && op == xfer_pkg::op_memory_store_xor_x
    |-> ram_we && ram_wdata == acc && ram_addr == data_pointer)
    else $error("store did not write");
  skip_quiet_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    op_valid && skip_next |=> $stable(acc) && $stable(reg_x) && $stable(reg_y) && !skip_next)
    else $error("skipped op had effect");
  skip_regs_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    op_valid && skip_next
    |=> $stable(reg_b) && $stable(reg_e) && $stable(reg_d) && $stable(reg_z))
    else $error("skipped op touched b e d or z");
  other_quiet_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    op_valid && op == xfer_pkg::op_nop
    |=> $stable(acc) && $stable(reg_x) && $stable(reg_y) && $stable(reg_b) && !skip_next)
    else $error("other op had effect here");
  load_acc_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    live && op == xfer_pkg::op_memory_load_xor_x |=> acc == $past(ram_rdata))
    else $error("memory load wrong");

endmodule : nibble_xfer_exec

/* common/xfer_pkg.sv */
// shared constants and the operation enumeration for the transfer executor
package xfer_pkg;
  localparam int ACC_W = 4;
  localparam int E_W   = 8;
  localparam int D_W   = 3;
  localparam int STACK_W = 3;
  localparam int Z_W   = 2;
  localparam int RAM_AW = 8;
  localparam logic [3:0] ACC_RST = 4'h0;
  localparam logic [3:0] B_RST   = 4'h0;
  localparam logic [3:0] X_RST   = 4'h0;
  localparam logic [3:0] Y_RST   = 4'h0;
  localparam logic [7:0] E_RST   = 8'h00;
  localparam logic [2:0] D_RST   = 3'h0;
  localparam logic [1:0] Z_RST   = 2'h0;
  localparam logic [3:0] Y_WRAP_DEC = 4'hf;
  localparam logic [3:0] Y_WRAP_INC = 4'h0;
  localparam logic [3:0] ONE4 = 4'h1;

  typedef enum logic [4:0] {
    op_nop,
    op_copy_b_to_acc,
    op_copy_acc_to_b,
    op_copy_y_to_acc,
    op_copy_acc_to_y,
    op_pack_e_from_b_acc,
    op_unpack_e_to_b_acc,
    op_load_d_from_acc,
    op_read_d_to_acc,
    op_read_z_to_acc,
    op_copy_x_to_acc,
    op_read_stack_ptr_to_acc,
    op_load_xy_immediate,
    op_load_z_immediate,
    op_increment_y_skip,
    op_decrement_y_skip,
    op_memory_load_xor_x,
    op_memory_exchange_xor_x,
    op_memory_exchange_dec_y,
    op_memory_exchange_inc_y,
    op_memory_store_xor_x
  } op_t;
endpackage : xfer_pkg

/* sim/data_ram_model.sv */
// behavioural data ram seen through the data pointer
`timescale 1ns/1ps
module data_ram_model #(
  parameter int AW = 8
) (
  // clock
  input  wire logic          sys_clk,
  // access port
  input  wire logic [AW-1:0] addr,
  input  wire logic          we,
  input  wire logic [3:0]    wdata,
  output logic      [3:0]    rdata
);
  logic [3:0] mem [2**AW];
  // known fill, so a read before any write is still predictable
  initial for (int i = 0; i < 2**AW; i++) mem[i] = 4'(i) ^ 4'ha;
  // async read, as the executor expects
  assign rdata = mem[addr];
  // write lands on the edge that ends the access cycle
  always @(posedge sys_clk) begin
    if (we) mem[addr] <= wdata;
  end
endmodule : data_ram_model

/* sim/tb.sv */
// self-checking bench for the transfer executor
`timescale 1ns/1ps
module tb;
  logic          sys_clk       = 1'b0;
  logic          rstn          = 1'b0;
  logic          op_valid      = 1'b0;
  xfer_pkg::op_t op            = xfer_pkg::op_nop;
  logic [3:0]    imm_a         = 4'h0;
  logic [3:0]    imm_b         = 4'h0;
  logic [2:0]    stack_pointer = 3'h0;
  logic          carry_in      = 1'b0;
  logic [7:0]    data_pointer  = 8'h00;
  logic [3:0]    ram_rdata, ram_wdata, acc, reg_b, reg_x, reg_y;
  logic [7:0]    ram_addr, reg_e;
  logic [2:0]    reg_d;
  logic [1:0]    reg_z;
  logic          ram_we, carry_flag, skip_pending, op_executed, we_seen, live;
  int            failures = 0;
  int            compares = 0;
  int            cycles   = 0;

  nibble_xfer_exec u_nibble_xfer_exec (.sys_clk, .rstn, .op_valid, .op, .imm_a, .imm_b,
    .stack_pointer, .carry_in, .data_pointer, .ram_rdata, .ram_addr, .ram_we, .ram_wdata,
    .acc, .reg_b, .reg_x, .reg_y, .reg_e, .reg_d, .reg_z, .carry_flag, .skip_pending,
    .op_executed);
  data_ram_model u_ram (.sys_clk, .addr(ram_addr), .we(ram_we), .wdata(ram_wdata),
    .rdata(ram_rdata));

  // clock and hang guard; under sixty cycles are needed, so 1000 is ample
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      failures++;
      finish_test();
    end
  end

  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // one fetched op; combinational outputs sampled mid-cycle
  task automatic step(xfer_pkg::op_t o, logic [3:0] a = 4'h0, logic [3:0] b = 4'h0);
    op_valid = 1'b1;
    op = o;
    imm_a = a;
    imm_b = b;
    #2;
    live = op_executed;
    we_seen = ram_we;
    @(posedge sys_clk);
    #1;
  endtask : step

  // one cycle with no fetched op; skip and repeat state must survive it
  task automatic idle();
    op_valid = 1'b0;
    op = xfer_pkg::op_nop;
    #2;
    chk("we", ram_we, 1'b0);
    @(posedge sys_clk);
    #1;
  endtask : idle

  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  task automatic t_regs();
    step(xfer_pkg::op_load_xy_immediate, 4'h5, 4'h9);
    chk("x", reg_x, 4'h5);
    chk("y", reg_y, 4'h9);
    step(xfer_pkg::op_copy_y_to_acc);
    chk("acc", acc, 4'h9);
    step(xfer_pkg::op_copy_acc_to_b);
    chk("b", reg_b, 4'h9);
    step(xfer_pkg::op_copy_x_to_acc);
    chk("acc", acc, 4'h5);
    step(xfer_pkg::op_copy_acc_to_y);
    chk("y", reg_y, 4'h5);
    step(xfer_pkg::op_pack_e_from_b_acc);
    chk("e", reg_e, 8'h95);
    step(xfer_pkg::op_copy_b_to_acc);
    chk("acc", acc, 4'h9);
    step(xfer_pkg::op_unpack_e_to_b_acc);
    chk("acc", acc, 4'h5);
    chk("b", reg_b, 4'h9);
    step(xfer_pkg::op_load_xy_immediate, 4'he, 4'h0);
    step(xfer_pkg::op_copy_x_to_acc);
    step(xfer_pkg::op_load_d_from_acc);
    chk("d", reg_d, 3'h6);
    step(xfer_pkg::op_read_d_to_acc);
    chk("acc", acc, 4'h6);
    step(xfer_pkg::op_load_z_immediate, 4'hb);
    chk("z", reg_z, 2'h3);
    step(xfer_pkg::op_read_z_to_acc);
    chk("acc", acc, 4'h3);
    stack_pointer = 3'h7;
    carry_in = 1'b1;
    step(xfer_pkg::op_read_stack_ptr_to_acc);
    chk("acc", acc, 4'h7);
    chk("carry", carry_flag, 1'b1);
    $display("test regs done");
  endtask : t_regs

  task automatic t_xy_repeat();
    step(xfer_pkg::op_load_xy_immediate, 4'h1, 4'h2);
    step(xfer_pkg::op_load_xy_immediate, 4'h3, 4'h4);
    step(xfer_pkg::op_load_xy_immediate, 4'h5, 4'h6);
    chk("x", reg_x, 4'h1);
    chk("y", reg_y, 4'h2);
    step(xfer_pkg::op_nop);
    step(xfer_pkg::op_load_xy_immediate, 4'h7, 4'h8);
    chk("x", reg_x, 4'h7);
    idle();
    step(xfer_pkg::op_load_xy_immediate, 4'ha, 4'hb);
    chk("x", reg_x, 4'h7);
    chk("y", reg_y, 4'h8);
    $display("test xy repeat done");
  endtask : t_xy_repeat

  task automatic t_skip();
    step(xfer_pkg::op_nop);
    step(xfer_pkg::op_load_xy_immediate, 4'h0, 4'hf);
    step(xfer_pkg::op_increment_y_skip);
    chk("y", reg_y, 4'h0);
    idle();
    step(xfer_pkg::op_copy_y_to_acc);
    chk("live", live, 1'b0);
    chk("acc", acc, 4'h7);
    step(xfer_pkg::op_decrement_y_skip);
    chk("y", reg_y, 4'hf);
    step(xfer_pkg::op_copy_x_to_acc);
    chk("acc", acc, 4'h7);
    step(xfer_pkg::op_decrement_y_skip);
    chk("skip", skip_pending, 1'b0);
    step(xfer_pkg::op_increment_y_skip);
    chk("skip", skip_pending, 1'b0);
    chk("y", reg_y, 4'hf);
    $display("test skip done");
  endtask : t_skip

  task automatic t_mem();
    data_pointer = 8'h3c;
    step(xfer_pkg::op_memory_store_xor_x, 4'h3);
    chk("we", we_seen, 1'b1);
    chk("mem", u_ram.mem[8'h3c], 4'h7);
    chk("x", reg_x, 4'h3);
    step(xfer_pkg::op_load_xy_immediate, 4'h9, 4'h1);
    step(xfer_pkg::op_copy_x_to_acc);
    step(xfer_pkg::op_memory_exchange_xor_x, 4'h5);
    chk("acc", acc, 4'h7);
    chk("mem", u_ram.mem[8'h3c], 4'h9);
    chk("x", reg_x, 4'hc);
    step(xfer_pkg::op_memory_load_xor_x, 4'hf);
    chk("acc", acc, 4'h9);
    chk("x", reg_x, 4'h3);
    step(xfer_pkg::op_load_xy_immediate, 4'h0, 4'hf);
    data_pointer = 8'h00;
    step(xfer_pkg::op_memory_exchange_inc_y, 4'h6);
    chk("acc", acc, 4'ha);
    chk("y", reg_y, 4'h0);
    step(xfer_pkg::op_memory_exchange_dec_y, 4'h6);
    chk("we", we_seen, 1'b0);
    chk("x", reg_x, 4'h6);
    step(xfer_pkg::op_memory_exchange_dec_y, 4'h1);
    chk("mem", u_ram.mem[8'h00], 4'ha);
    chk("y", reg_y, 4'hf);
    chk("skip", skip_pending, 1'b1);
    $display("test mem done");
  endtask : t_mem

  initial begin
    repeat (16) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    chk("acc_rst", acc, xfer_pkg::ACC_RST);
    t_regs();
    t_xy_repeat();
    t_skip();
    t_mem();
    finish_test();
  end
endmodule : tb
